// ### duty_limiter_pkg.sv
package duty_limiter_pkg;
  // clock and duty scale
  localparam int CLK_HZ = 40_000_000;
  localparam int DUTY_W = 10;
  localparam int DUTY_FULL = (1 << DUTY_W) - 1;
  localparam int CNT_W = 24;
  // timing figures in their own units
  localparam int HALF_SEC_MS = 500;
  localparam int PH_TO_MS = 60;
  localparam int EXC_PERIOD_US = 1000;
  localparam int HALF_STEP_CYC = CLK_HZ / 1000 * HALF_SEC_MS / DUTY_FULL;
  localparam int PH_TO_CYC = CLK_HZ / 1000 * PH_TO_MS;
  // filter time constants, ms
  localparam int TAU0_MS = 35;
  localparam int TAU1_MS = 70;
  localparam int TAU2_MS = 140;
  localparam int TAU3_MS = 210;
  // fall times in half seconds
  localparam int FALL0_HALF = 2;
  localparam int FALL1_HALF = 4;
  localparam int FALL2_HALF = 5;
  localparam int FALL3_HALF = 6;
  // limiter disable speeds, rpm
  localparam logic [15:0] RPM0 = 16'h0BB8;
  localparam logic [15:0] RPM1 = 16'h0FA0;
  localparam logic [15:0] RPM2 = 16'h12C0;
  localparam logic [15:0] RPM3 = 16'h1770;
  // register byte offsets
  localparam logic [7:0] OFS_RISE = 8'h00;
  localparam logic [7:0] OFS_SPD = 8'h04;
  localparam logic [7:0] OFS_BLIND = 8'h08;
  localparam logic [7:0] OFS_DUTY = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_NV = 8'h14;
  // register values
  localparam logic [3:0] RISE_OFF = 4'h0;
  localparam logic [3:0] SPD_NEVER = 4'hF;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [9:0] BLIND_RST = 10'h014;
  // status bits
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_EN = 1;
  localparam int STAT_PVLOW = 2;
  // non-volatile field layout
  localparam int NV_W = 11;
  localparam int NV_SPD_LSB = 0;
  localparam int NV_RISE_LSB = 2;
  localparam int NV_FALL_LSB = 5;
  localparam int NV_FILT_LSB = 7;
  localparam int NV_MODE_LSB = 9;
  localparam int NV_MASK_LSB = 16;
  localparam logic [10:0] NV_DEFAULT = 11'h288;
  // filter input during boost
  typedef enum logic [1:0] {
    FIN_REG = 2'h0,
    FIN_PREEXC = 2'h1,
    FIN_ZERO = 2'h2,
    FIN_RSVD = 2'h3
  } filt_in_type;
endpackage : duty_limiter_pkg

// ### duty_ewma_filter.sv
`timescale 1ns/10ps
module duty_ewma_filter #(
  parameter int DW = duty_limiter_pkg::DUTY_W,
  parameter int PERIOD_US = duty_limiter_pkg::EXC_PERIOD_US
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sample side
  input wire logic upd,
  input wire logic [1:0] tau_sel,
  input wire logic [DW-1:0] x,
  // smoothed value
  output logic [DW-1:0] y
);
  logic [DW+15:0] acc_r;
  logic [16:0] alpha;
  logic signed [DW:0] diff;
  logic signed [DW+17:0] prod;
  logic signed [DW+18:0] sum;

  // weight is period over tau in q16; small-step approximation
  function automatic logic [16:0] alpha_of(input logic [1:0] s);
    longint tau;
    case (s)
      2'h0: tau = duty_limiter_pkg::TAU0_MS;
      2'h1: tau = duty_limiter_pkg::TAU1_MS;
      2'h2: tau = duty_limiter_pkg::TAU2_MS;
      default: tau = duty_limiter_pkg::TAU3_MS;
    endcase
    return 17'((longint'(65536) * PERIOD_US) / (tau * 1000));
  endfunction : alpha_of

  assign alpha = alpha_of(tau_sel);
  assign y = acc_r[DW+15:16];

  always_comb begin
    diff = $signed({1'b0, x}) - $signed({1'b0, y});
    prod = diff * $signed({1'b0, alpha});
    sum = $signed({3'h0, acc_r}) + prod;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
    end else if (upd) begin
      acc_r <= sum[DW+15:0];
    end
  end
endmodule : duty_ewma_filter

// ### excitation_duty_rise_limiter.sv
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - disabled: limiter and output follow regulator
// - regulator above limiter plus blind zone activates
// - regulator below limiter: inactive, ramp down
// - rise time spans zero to full scale
// - disable on overspeed or zero rise setting
// - register enable starts at applied duty
// - speed re-enable or low-voltage on forces full
// - boost jumps leave limiter untouched
// - final duty feeds the moving-average filter
// - boost selects filter input by mode field
// - filter time constant matches selected time
// - filter output is the readback duty
// - phase loss raises timeout after 60 ms
// - stored values preset config on reset, wake
// - unprogrammed stored bits read default
// - disable speed field decodes four speeds
// - rise field decodes one to eight seconds
// - fall field decodes one to three seconds
// - everything runs on the oscillator clock
// - low supply during programming sets flag
// - stored bits programmed only in test mode
// - boost mode picks regulation, pre-excite, zero
// - filter field picks 35 to 210 ms
module excitation_duty_rise_limiter #(
  parameter int DW = duty_limiter_pkg::DUTY_W,
  parameter int HALF_STEP_CYC = duty_limiter_pkg::HALF_STEP_CYC,
  parameter int PH_TO_CYC = duty_limiter_pkg::PH_TO_CYC,
  parameter int PERIOD_US = duty_limiter_pkg::EXC_PERIOD_US
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // regulator side
  input wire logic [DW-1:0] reg_duty,
  input wire logic [DW-1:0] preexc_duty,
  input wire logic [15:0] rotor_speed,
  input wire logic phase_boost,
  input wire logic boost_on,
  input wire logic low_voltage_excite_on,
  input wire logic phase_edge,
  input wire logic exc_period,
  // state machine side
  input wire logic wakeup_preset,
  input wire logic default_op_entry,
  input wire logic test_mode,
  input wire logic prog_active,
  input wire logic supply_low,
  // outputs
  output logic [DW-1:0] excite_duty,
  output logic phase_timeout,
  output logic prog_voltage_low
);
  localparam int CW = duty_limiter_pkg::CNT_W;
  localparam logic [DW-1:0] FULL = '1;

  // bus state
  logic wr_q;
  logic [7:0] addr_q;
  // configuration
  logic [3:0] rise_time_setting_reg;
  logic [3:0] speed_disable_setting_reg;
  logic [1:0] fall_sel_r;
  logic [DW-1:0] blind_r;
  logic preset_pend_r;
  logic preset_req;
  // stored bits
  logic [10:0] nv_val_r;
  logic [10:0] nv_prog_r;
  logic [10:0] nonvolatile_store;
  logic [10:0] nv_mask;
  // limiter
  logic [DW-1:0] lim_r;
  logic active_r;
  logic lim_en;
  logic lim_en_q;
  logic speed_over;
  logic speed_over_q;
  logic speed_cross;
  logic lvon_q;
  logic lvon_rise;
  logic reg_over;
  logic [DW:0] lim_blind;
  logic [DW-1:0] excite_nxt;
  logic [CW-1:0] rise_cnt_r;
  logic [CW-1:0] fall_cnt_r;
  logic [CW-1:0] rise_lim;
  logic [CW-1:0] fall_lim;
  logic rise_tick;
  logic fall_tick;
  // filter, timeout, supply
  logic [DW-1:0] fin;
  logic [DW-1:0] duty_readback_reg;
  logic [CW-1:0] ph_cnt_r;
  logic sup_s1;
  logic sup_s2;
  logic pv_clr;

  function automatic logic [15:0] dis_rpm(input logic [1:0] c);
    case (c)
      2'h0: return duty_limiter_pkg::RPM0;
      2'h1: return duty_limiter_pkg::RPM1;
      2'h2: return duty_limiter_pkg::RPM2;
      default: return duty_limiter_pkg::RPM3;
    endcase
  endfunction : dis_rpm

  function automatic int fall_half(input logic [1:0] c);
    case (c)
      2'h0: return duty_limiter_pkg::FALL0_HALF;
      2'h1: return duty_limiter_pkg::FALL1_HALF;
      2'h2: return duty_limiter_pkg::FALL2_HALF;
      default: return duty_limiter_pkg::FALL3_HALF;
    endcase
  endfunction : fall_half

  function automatic logic hit(input logic [7:0] ofs);
    return wr_q && addr_q == ofs;
  endfunction : hit

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    case (addr_q)
      duty_limiter_pkg::OFS_RISE: hrdata[3:0] = rise_time_setting_reg;
      duty_limiter_pkg::OFS_SPD: hrdata[3:0] = speed_disable_setting_reg;
      duty_limiter_pkg::OFS_BLIND: hrdata[DW-1:0] = blind_r;
      duty_limiter_pkg::OFS_DUTY: hrdata[DW-1:0] = duty_readback_reg;
      duty_limiter_pkg::OFS_STAT: begin
        hrdata[duty_limiter_pkg::STAT_ACTIVE] = active_r;
        hrdata[duty_limiter_pkg::STAT_EN] = lim_en;
        hrdata[duty_limiter_pkg::STAT_PVLOW] = prog_voltage_low;
      end
      duty_limiter_pkg::OFS_NV: hrdata[10:0] = nonvolatile_store;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // stored bits; erased model, a real store survives reset
  assign nonvolatile_store = (nv_val_r & nv_prog_r)
                           | (duty_limiter_pkg::NV_DEFAULT & ~nv_prog_r);
  assign nv_mask = hwdata[duty_limiter_pkg::NV_MASK_LSB +: 11];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_val_r <= 11'h000;
      nv_prog_r <= 11'h000;
    end else if (hit(duty_limiter_pkg::OFS_NV) && test_mode) begin
      nv_val_r <= (nv_val_r & ~nv_mask) | (hwdata[10:0] & nv_mask);
      nv_prog_r <= nv_prog_r | nv_mask;
    end
  end

  // preset once after reset release, and on wake or default entry
  assign preset_req = preset_pend_r || wakeup_preset || default_op_entry;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_pend_r <= 1'b1;
    end else begin
      preset_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_time_setting_reg <= duty_limiter_pkg::CFG_RST;
      speed_disable_setting_reg <= duty_limiter_pkg::CFG_RST;
      fall_sel_r <= 2'h0;
    end else if (preset_req) begin
      rise_time_setting_reg <= 4'(nonvolatile_store[
        duty_limiter_pkg::NV_RISE_LSB +: 3]) + 4'h1;
      speed_disable_setting_reg <= {2'h0, nonvolatile_store[
        duty_limiter_pkg::NV_SPD_LSB +: 2]};
      fall_sel_r <= nonvolatile_store[duty_limiter_pkg::NV_FALL_LSB +: 2];
    end else begin
      if (hit(duty_limiter_pkg::OFS_RISE)) begin
        rise_time_setting_reg <= hwdata[3:0];
      end
      if (hit(duty_limiter_pkg::OFS_SPD)) begin
        speed_disable_setting_reg <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blind_r <= DW'(duty_limiter_pkg::BLIND_RST);
    end else if (hit(duty_limiter_pkg::OFS_BLIND)) begin
      blind_r <= hwdata[DW-1:0];
    end
  end

  // enable conditions
  assign speed_over = rotor_speed >
    dis_rpm(speed_disable_setting_reg[1:0])
    && speed_disable_setting_reg != duty_limiter_pkg::SPD_NEVER;
  assign lim_en = rise_time_setting_reg != duty_limiter_pkg::RISE_OFF
                  && !speed_over;
  assign speed_cross = speed_over_q && !speed_over;
  assign lvon_rise = low_voltage_excite_on && !lvon_q;
  assign lim_blind = {1'b0, lim_r} + {1'b0, blind_r};
  assign reg_over = {1'b0, reg_duty} > lim_blind;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_en_q <= 1'b0;
      speed_over_q <= 1'b0;
      lvon_q <= 1'b0;
    end else begin
      lim_en_q <= lim_en;
      speed_over_q <= speed_over;
      lvon_q <= low_voltage_excite_on;
    end
  end

  // slow ticks: one count per step, full ramp in the set time
  assign rise_lim = CW'(int'(rise_time_setting_reg) * 2 * HALF_STEP_CYC);
  assign fall_lim = CW'(fall_half(fall_sel_r) * HALF_STEP_CYC);
  assign rise_tick = rise_cnt_r == '0;
  assign fall_tick = fall_cnt_r == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else begin
      // reload when the limit shrinks, else a stale count stalls the ramp
      rise_cnt_r <= (rise_tick || rise_cnt_r >= rise_lim)
                    ? rise_lim - 1'b1 : rise_cnt_r - 1'b1;
      fall_cnt_r <= (fall_tick || fall_cnt_r >= fall_lim)
                    ? fall_lim - 1'b1 : fall_cnt_r - 1'b1;
    end
  end

  // limiter value and activity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_r <= '0;
      active_r <= 1'b0;
    end else if (phase_boost) begin
      lim_r <= lim_r;
    end else if (!lim_en) begin
      lim_r <= reg_duty;
      active_r <= 1'b0;
    end else if (!lim_en_q) begin
      // speed re-enable goes full, a register write starts at output
      lim_r <= speed_cross ? FULL : excite_duty;
      active_r <= 1'b0;
    end else if (lvon_rise) begin
      lim_r <= FULL;
    end else begin
      if (reg_duty < lim_r) begin
        active_r <= 1'b0;
      end else if (reg_over) begin
        active_r <= 1'b1;
      end
      if (active_r && reg_duty > lim_r && rise_tick) begin
        lim_r <= lim_r + 1'b1;
      end else if (!active_r && reg_duty < lim_r && fall_tick) begin
        lim_r <= lim_r - 1'b1;
      end
    end
  end

  // applied duty; boost bypasses the limiter entirely
  always_comb begin
    if (phase_boost) begin
      excite_nxt = boost_on ? FULL : '0;
    end else if (!lim_en) begin
      excite_nxt = reg_duty;
    end else if ((active_r || reg_over) && reg_duty > lim_r) begin
      excite_nxt = lim_r;
    end else begin
      excite_nxt = reg_duty;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      excite_duty <= '0;
    end else begin
      excite_duty <= excite_nxt;
    end
  end

  // filter input; reserved mode falls back to regulation duty
  always_comb begin
    fin = excite_nxt;
    if (phase_boost) begin
      case (duty_limiter_pkg::filt_in_type'(nonvolatile_store[
            duty_limiter_pkg::NV_MODE_LSB +: 2]))
        duty_limiter_pkg::FIN_PREEXC: fin = preexc_duty;
        duty_limiter_pkg::FIN_ZERO: fin = '0;
        default: fin = reg_duty;
      endcase
    end
  end

  duty_ewma_filter #(
    .DW(DW),
    .PERIOD_US(PERIOD_US)
  ) duty_ewma_filter_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .upd(exc_period),
    .tau_sel(nonvolatile_store[duty_limiter_pkg::NV_FILT_LSB +: 2]),
    .x(fin),
    .y(duty_readback_reg)
  );

  // phase loss timeout, one pulse per loss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_cnt_r <= '0;
      phase_timeout <= 1'b0;
    end else begin
      phase_timeout <= !phase_edge
                       && ph_cnt_r == CW'(PH_TO_CYC - 1);
      if (phase_edge) begin
        ph_cnt_r <= '0;
      end else if (ph_cnt_r != CW'(PH_TO_CYC)) begin
        ph_cnt_r <= ph_cnt_r + 1'b1;
      end
    end
  end

  // comparator is asynchronous to the oscillator clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
    end else begin
      sup_s1 <= supply_low;
      sup_s2 <= sup_s1;
    end
  end

  assign pv_clr = hit(duty_limiter_pkg::OFS_STAT)
                  && hwdata[duty_limiter_pkg::STAT_PVLOW];

  // set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_voltage_low <= 1'b0;
    end else begin
      prog_voltage_low <= (prog_active && sup_s2)
                          || (prog_voltage_low && !pv_clr);
    end
  end

  // single oscillator clock hclk for all logic

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bypass_duty_a: assert property (
    !phase_boost && !lim_en |=> excite_duty == $past(reg_duty))
    else $error("bypass duty not applied");

  limit_activate_a: assert property (
    !phase_boost && lim_en && lim_en_q && !lvon_rise && reg_over
    |=> active_r)
    else $error("limiter did not activate");

  limit_release_a: assert property (
    !phase_boost && lim_en && lim_en_q && !lvon_rise
    && reg_duty < lim_r |=> !active_r)
    else $error("limiter did not release");

  rise_step_a: assert property (
    !phase_boost && lim_en && lim_en_q && !lvon_rise && active_r
    && reg_duty > lim_r && rise_tick |=> lim_r == $past(lim_r) + 1'b1)
    else $error("rise step missing");

  zero_rise_a: assert property (
    rise_time_setting_reg == duty_limiter_pkg::RISE_OFF |-> !lim_en)
    else $error("limiter enabled with zero rise");

  write_start_a: assert property (
    !phase_boost && lim_en && !lim_en_q && !speed_cross
    |=> lim_r == $past(excite_duty))
    else $error("start value not applied duty");

  full_force_a: assert property (
    !phase_boost && lim_en && (!lim_en_q && speed_cross
    || lim_en_q && lvon_rise) |=> lim_r == FULL)
    else $error("limiter not forced full");

  boost_hold_a: assert property (
    phase_boost |=> $stable(lim_r) && $stable(active_r))
    else $error("boost altered limiter");

  phase_loss_a: assert property (
    phase_timeout |-> $past(ph_cnt_r) == CW'(PH_TO_CYC - 1))
    else $error("timeout at wrong count");

  pv_flag_a: assert property (
    prog_active && sup_s2 |=> prog_voltage_low)
    else $error("programming low flag missed");

  nv_lock_a: assert property (
    !test_mode |=> $stable(nv_prog_r))
    else $error("stored bits changed outside test");
endmodule : excitation_duty_rise_limiter

// ### duty_regulator_model.sv
`timescale 1ns/10ps
module duty_regulator_model #(
  parameter int PER = 4,
  parameter int PH = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // commands from the bench
  input wire logic [duty_limiter_pkg::DUTY_W-1:0] dem,
  input wire logic per_run,
  input wire logic ph_run,
  // toward the limiter
  output logic [duty_limiter_pkg::DUTY_W-1:0] reg_duty,
  output logic exc_period,
  output logic phase_edge
);
  int per_cnt;
  int ph_cnt;
  // demand is registered, as a real regulator core would be
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reg_duty <= '0;
    else reg_duty <= dem;
  end
  // one strobe per excitation period, only while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt <= 0;
      exc_period <= 1'b0;
    end else begin
      per_cnt <= (per_cnt == PER - 1) ? 0 : per_cnt + 1;
      exc_period <= per_run && (per_cnt == PER - 1);
    end
  end
  // phase edges stop dead when the phase signal is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_cnt <= 0;
      phase_edge <= 1'b0;
    end else begin
      ph_cnt <= (ph_cnt == PH - 1) ? 0 : ph_cnt + 1;
      phase_edge <= ph_run && (ph_cnt == PH - 1);
    end
  end
endmodule : duty_regulator_model

// ### excitation_duty_rise_limiter_tb_top.sv
`timescale 1ns/10ps
module excitation_duty_rise_limiter_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] dem, reg_duty, excite_duty;
  logic [15:0] rotor_speed;
  logic [15:0] rpm_tab [4];
  logic per_run, ph_run, exc_period, phase_edge, phase_boost, lveo, boost_on;
  logic wakeup_preset, default_op_entry, test_mode, prog_active, supply_low;
  logic phase_timeout, prog_voltage_low;
  int n_fail, checks, n_to;
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (phase_timeout === 1'b1) n_to++;
  duty_regulator_model duty_regulator_model_inst (.hclk(hclk),
    .hresetn(hresetn), .dem(dem), .per_run(per_run), .ph_run(ph_run),
    .reg_duty(reg_duty), .exc_period(exc_period), .phase_edge(phase_edge));
  excitation_duty_rise_limiter #(.HALF_STEP_CYC(4), .PH_TO_CYC(50))
    excitation_duty_rise_limiter_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reg_duty(reg_duty), .preexc_duty(10'h080), .rotor_speed(rotor_speed),
    .phase_boost(phase_boost), .boost_on(boost_on),
    .low_voltage_excite_on(lveo), .phase_edge(phase_edge),
    .exc_period(exc_period), .wakeup_preset(wakeup_preset),
    .default_op_entry(default_op_entry), .test_mode(test_mode),
    .prog_active(prog_active), .supply_low(supply_low),
    .excite_duty(excite_duty), .phase_timeout(phase_timeout),
    .prog_voltage_low(prog_voltage_low));
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rng(input string nm, input int lo, input int hi,
           input logic [31:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask : rng
  // single ahb-lite word transfer; read data lands in v
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    v = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    $display("BAD watchdog expired");
    results();
  end
  initial begin
    {hresetn, hsel, hwrite, per_run, phase_boost, lveo, boost_on} = '0;
    {wakeup_preset, default_op_entry, test_mode, prog_active} = '0;
    {haddr, hwdata, htrans, dem, rotor_speed, supply_low} = '0;
    hsize = 3'h2;
    ph_run = 1'b1;
    rpm_tab = '{16'h0BB8, 16'h0FA0, 16'h12C0, 16'h1770};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    bus(0, duty_limiter_pkg::OFS_RISE, 0); chk("rise", 32'h3, v);
    bus(0, duty_limiter_pkg::OFS_SPD, 0); chk("spd", 32'h0, v);
    bus(0, duty_limiter_pkg::OFS_BLIND, 0); chk("blind", 32'h14, v);
    bus(0, duty_limiter_pkg::OFS_NV, 0); chk("nv", 32'h288, v);
    bus(0, 8'h40, 0); chk("unmapped", 32'h0, v);
    $display("register defaults done");
    // filter step from zero, limiter off
    bus(1, duty_limiter_pkg::OFS_RISE, 32'h0);
    dem <= 10'h200;
    per_run <= 1'b1;
    cyc(3); chk("follow", 32'h200, excite_duty);
    cyc(276);
    bus(0, duty_limiter_pkg::OFS_DUTY, 0); rng("tau", 290, 355, v);
    cyc(2000);
    bus(0, duty_limiter_pkg::OFS_DUTY, 0); rng("settle", 505, 515, v);
    phase_boost <= 1'b1;
    cyc(2000);
    bus(0, duty_limiter_pkg::OFS_DUTY, 0); rng("boost", 124, 132, v);
    phase_boost <= 1'b0;
    per_run <= 1'b0;
    $display("filter done");
    // rise limiting from the applied duty
    dem <= 10'h064;
    cyc(4);
    bus(1, duty_limiter_pkg::OFS_RISE, 32'h1);
    dem <= 10'h258;
    cyc(80); rng("ramp", 104, 116, excite_duty);
    bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("stat", 32'h3, v);
    boost_on <= 1'b1;
    phase_boost <= 1'b1;
    cyc(3); chk("boost full", 32'h3FF, excite_duty);
    phase_boost <= 1'b0;
    boost_on <= 1'b0;
    cyc(2); rng("boost hold", 104, 116, excite_duty);
    dem <= 10'h032;
    cyc(4); chk("drop", 32'h32, excite_duty);
    lveo <= 1'b1;
    cyc(2);
    lveo <= 1'b0;
    dem <= 10'h384;
    cyc(4); chk("leo", 32'h384, excite_duty);
    rotor_speed <= 16'h0FA0;
    cyc(3);
    dem <= 10'h2BC;
    cyc(4); chk("overspeed", 32'h2BC, excite_duty);
    rotor_speed <= 16'h0100;
    cyc(3);
    dem <= 10'h3E8;
    cyc(4); chk("speed down", 32'h3E8, excite_duty);
    for (int i = 0; i < 4; i++) begin
      bus(1, duty_limiter_pkg::OFS_SPD, i);
      rotor_speed <= rpm_tab[i];
      bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("en at", 32'h1, v[1]);
      rotor_speed <= rpm_tab[i] + 16'h0001;
      bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("en above", 32'h0, v[1]);
    end
    bus(1, duty_limiter_pkg::OFS_SPD, 32'hF);
    rotor_speed <= 16'hFFFF;
    bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("never", 32'h1, v[1]);
    bus(1, duty_limiter_pkg::OFS_RISE, 32'h0);
    bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("rise off", 32'h0, v[1]);
    $display("limiter done");
    // phase loss
    n_to = 0;
    ph_run <= 1'b0;
    cyc(38); chk("early", 32'h0, n_to);
    cyc(24); chk("timeout", 32'h1, n_to);
    cyc(150); chk("once", 32'h1, n_to);
    ph_run <= 1'b1;
    $display("phase loss done");
    // supply during programming
    supply_low <= 1'b1;
    cyc(5); chk("pv idle", 32'h0, prog_voltage_low);
    prog_active <= 1'b1;
    cyc(5); chk("pv low", 32'h1, prog_voltage_low);
    supply_low <= 1'b0;
    prog_active <= 1'b0;
    cyc(4);
    bus(1, duty_limiter_pkg::OFS_STAT, 32'h4);
    bus(0, duty_limiter_pkg::OFS_STAT, 0); chk("pv clr", 32'h0, v[2]);
    $display("programming supply done");
    // stored bits, rise field cleared to code 000
    bus(1, duty_limiter_pkg::OFS_NV, 32'h001C0000);
    bus(0, duty_limiter_pkg::OFS_NV, 0); chk("nv locked", 32'h288, v);
    test_mode <= 1'b1;
    bus(1, duty_limiter_pkg::OFS_NV, 32'h001C0000);
    bus(0, duty_limiter_pkg::OFS_NV, 0); chk("nv prog", 32'h280, v);
    test_mode <= 1'b0;
    wakeup_preset <= 1'b1;
    cyc(1);
    wakeup_preset <= 1'b0;
    cyc(2);
    bus(0, duty_limiter_pkg::OFS_RISE, 0); chk("wake", 32'h1, v);
    bus(1, duty_limiter_pkg::OFS_RISE, 32'h5);
    default_op_entry <= 1'b1;
    cyc(1);
    default_op_entry <= 1'b0;
    cyc(2);
    bus(0, duty_limiter_pkg::OFS_RISE, 0); chk("default op", 32'h1, v);
    $display("stored bits done");
    // boost filter input: zero, then regulation duty
    test_mode <= 1'b1;
    bus(1, duty_limiter_pkg::OFS_NV, 32'h06000400);
    phase_boost <= 1'b1;
    per_run <= 1'b1;
    cyc(2000);
    bus(0, duty_limiter_pkg::OFS_DUTY, 0); rng("zero mode", 0, 4, v);
    bus(1, duty_limiter_pkg::OFS_NV, 32'h06000000);
    cyc(2000);
    bus(0, duty_limiter_pkg::OFS_DUTY, 0); rng("reg mode", 990, 1000, v);
    test_mode <= 1'b0;
    phase_boost <= 1'b0;
    per_run <= 1'b0;
    $display("boost modes done");
    results();
  end
endmodule : excitation_duty_rise_limiter_tb_top
